// *** verilog/gstc_timer.sv ***
// gated sixteen-bit timer/counter with an AXI4-Lite register slave
// Function
// RL1 - prescale field bits 5-4 divides input by 1, 2, 4 or 8
// RL2 - bit 3 enables low-power oscillator only in internal-oscillator mode
// RL3 - with external source, bit 2 set bypasses synchroniser, clear synchronises
// RL4 - with internal source, sync bit ignored, internal clock used
// RL5 - bit 1 picks external rising edges or internal clock at quarter rate
// RL6 - bit 0 starts the timer when set, stops it when clear
// RL7 - control bit 7 is unimplemented and reads zero
// RL8 - sync disabled: counter steps straight from the external input
// RL9 - asynchronous counter keeps counting in sleep, overflow can wake
// RL10 - software takes care accessing the count while it runs asynchronously
// RL11 - software sets analog and comparator config before digital pin use
// RL12 - a pin configured analog reads zero as a digital input
// RL13 - gate input can gate the timer clock in both modes
// RL14 - rollover from maximum to zero sets the overflow flag
// RL15 - prescaler is hidden and cleared by any count byte write
// RL16 - external counting needs a falling edge before first rising edge
// RL17 - gate enabled: count only while active-low gate is low
//
// Added by the designer: register access over AXI4-Lite.
module gstc_timer
   import gstc_pkg::*;
#(
   parameter int INT_DIV = GSTC_INT_DIV
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic external_clock_input,
   input wire logic lp_osc_input,
   input wire logic gate_input_pin_n,
   input wire logic internal_oscillator_mode,
   input wire logic sleep_mode,
   output logic low_power_osc_run,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      gstc_chan_t wst;
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic [1:0] bresp;
      gstc_chan_t rst;
      logic [7:0] raddr;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [6:0] ctrl;
      logic [15:0] count;
      logic [2:0] presc;
      logic status;
      logic mask;
      logic [1:0] analog;
   } gstc_st_t;

   gstc_st_t q, d;
   gstc_src_if sif();
   logic aw_hs, w_hs, do_wr, ar_hs, cnt_wr, st_w1c, run, inc, ovf_evt;
   logic ext_dig, gate_dig;
   logic [7:0] wa;
   logic [31:0] wd;
   logic [3:0] ws;
   logic [2:0] lim;
   logic [31:0] rd;
   logic [1:0] rr;

   ////////////////////////////////////////////////////////////////////
   // pin conditioning and tick source
   assign ext_dig = external_clock_input & ~q.analog[GSTC_AN_CLK_BIT]; // [RL12]
   assign gate_dig = gate_input_pin_n & ~q.analog[GSTC_AN_GATE_BIT]; // [RL12]
   // oscillator runs only when its bit is set in internal-oscillator mode
   assign low_power_osc_run = q.ctrl[GSTC_OSC_BIT] & internal_oscillator_mode; // [RL2]
   assign sif.pin = low_power_osc_run ? lp_osc_input : ext_dig; // [RL2]
   assign sif.on = q.ctrl[GSTC_ON_BIT];
   assign sif.cs = q.ctrl[GSTC_CS_BIT];
   assign sif.sync_dis = q.ctrl[GSTC_SYNC_BIT];
   assign sif.sleep = sleep_mode;

   gstc_tick_src #(
      .INT_DIV(INT_DIV)
   ) u_src (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .sif(sif.src)
   );

   ////////////////////////////////////////////////////////////////////
   // bus handshakes
   assign s_axi_awready = !q.aw_have && (q.wst == GSTC_CH_IDLE);
   assign s_axi_wready = !q.w_have && (q.wst == GSTC_CH_IDLE);
   assign s_axi_bvalid = (q.wst == GSTC_CH_RESP);
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = (q.rst == GSTC_CH_IDLE);
   assign s_axi_rvalid = (q.rst == GSTC_CH_RESP);
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign irq = q.status & q.mask;

   assign aw_hs = s_axi_awvalid && s_axi_awready;
   assign w_hs = s_axi_wvalid && s_axi_wready;
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   assign wa = q.aw_have ? q.aw_addr : s_axi_awaddr;
   assign wd = q.w_have ? q.w_data : s_axi_wdata;
   assign ws = q.w_have ? q.w_strb : s_axi_wstrb;
   assign do_wr = (q.wst == GSTC_CH_IDLE) && (q.aw_have || aw_hs) && (q.w_have || w_hs);
   assign cnt_wr = do_wr && ws[0] && ((wa == GSTC_OFF_COUNT_LO) || (wa == GSTC_OFF_COUNT_HI));
   assign st_w1c = do_wr && ws[0] && (wa == GSTC_OFF_STATUS) && wd[0];

   ////////////////////////////////////////////////////////////////////
   // counting controls
   assign lim = 3'((4'h1 << q.ctrl[GSTC_PS_LSB+:2]) - 4'h1); // [RL1]
   // gate is active low and only matters while the gate enable is set
   assign run = q.ctrl[GSTC_ON_BIT] &&
                (!q.ctrl[GSTC_GATE_BIT] || !gate_dig); // [RL6] [RL13] [RL17]
   assign inc = run && sif.tick && !cnt_wr && (q.presc == lim); // [RL1]
   assign ovf_evt = inc && (q.count == GSTC_COUNT_MAX); // [RL14]

   ////////////////////////////////////////////////////////////////////
   // read data decode
   always_comb begin
      rd = 32'h0;
      rr = GSTC_RESP_OKAY;
      if (s_axi_araddr == GSTC_OFF_COUNT_LO) begin
         rd = {24'h0, q.count[7:0]};
      end else if (s_axi_araddr == GSTC_OFF_COUNT_HI) begin
         rd = {24'h0, q.count[15:8]};
      end else if (s_axi_araddr == GSTC_OFF_STATUS) begin
         rd = {31'h0, q.status};
      end else if (s_axi_araddr == GSTC_OFF_MASK) begin
         rd = {31'h0, q.mask};
      end else if (s_axi_araddr == GSTC_OFF_CTRL) begin
         rd = {24'h0, 1'b0, q.ctrl}; // [RL7]
      end else if (s_axi_araddr == GSTC_OFF_ANALOG) begin
         rd = {30'h0, q.analog};
      end else if (s_axi_araddr == GSTC_OFF_PINS) begin
         rd = {30'h0, gate_dig, ext_dig}; // [RL12]
      end else begin
         rr = GSTC_RESP_SLVERR;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      d = q;
      if (aw_hs) begin
         d.aw_have = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (w_hs) begin
         d.w_have = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      if (q.wst == GSTC_CH_RESP && s_axi_bready) begin
         d.wst = GSTC_CH_IDLE;
      end
      if (do_wr) begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.wst = GSTC_CH_RESP;
         d.bresp = GSTC_RESP_OKAY;
         if (wa == GSTC_OFF_COUNT_LO) begin
            if (ws[0]) begin
               d.count[7:0] = wd[7:0];
            end
         end else if (wa == GSTC_OFF_COUNT_HI) begin
            if (ws[0]) begin
               d.count[15:8] = wd[7:0];
            end
         end else if (wa == GSTC_OFF_STATUS) begin
            d.status = q.status;
         end else if (wa == GSTC_OFF_MASK) begin
            if (ws[0]) begin
               d.mask = wd[0];
            end
         end else if (wa == GSTC_OFF_CTRL) begin
            if (ws[0]) begin
               d.ctrl = wd[6:0]; // [RL7]
            end
         end else if (wa == GSTC_OFF_ANALOG) begin
            if (ws[0]) begin
               d.analog = wd[1:0];
            end
         end else if (wa == GSTC_OFF_PINS) begin
            d.bresp = GSTC_RESP_OKAY;
         end else begin
            d.bresp = GSTC_RESP_SLVERR;
         end
      end
      if (q.rst == GSTC_CH_RESP && s_axi_rready) begin
         d.rst = GSTC_CH_IDLE;
      end
      if (ar_hs) begin
         d.rst = GSTC_CH_RESP;
         d.raddr = s_axi_araddr;
         d.rdata = rd;
         d.rresp = rr;
      end
      // a count byte write wins over a tick in the same cycle
      if (cnt_wr) begin
         d.presc = 3'h0; // [RL15]
      end else if (run && sif.tick) begin
         d.presc = (q.presc == lim) ? 3'h0 : q.presc + 3'h1; // [RL1]
      end
      if (inc) begin
         d.count = q.count + 16'h1; // [RL14]
      end
      if (st_w1c) begin
         d.status = 1'b0;
      end
      // a new overflow beats a clear in the same cycle
      if (ovf_evt) begin
         d.status = 1'b1; // [RL14] [RL9]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.ctrl <= GSTC_CTRL_RST;
         q.analog <= GSTC_ANALOG_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_count_write;
      ce && cnt_wr;
   endsequence
   sequence s_hold_case;
      ce && !cnt_wr;
   endsequence

   a_ctrl_bit7_zero: assert property (s_axi_rvalid && q.raddr == GSTC_OFF_CTRL
      |-> s_axi_rdata[7] == 1'b0) // [RL7]
      else $error("control bit 7 read back nonzero");
   a_presc_clear: assert property (s_count_write |=> q.presc == 3'h0) // [RL15]
      else $error("prescaler not cleared by count write");
   a_presc_wrap: assert property (ce && run && sif.tick && !cnt_wr && q.presc == lim
      |=> q.presc == 3'h0 && q.count == $past(q.count) + 16'h1) // [RL1]
      else $error("prescaler wrap did not step the count");
   a_presc_step: assert property (ce && run && sif.tick && !cnt_wr && q.presc != lim
      && q.presc < lim |=> $stable(q.count)) // [RL1]
      else $error("count stepped before prescaler reached its limit");
   a_ovf_set: assert property (ce && inc && q.count == GSTC_COUNT_MAX
      |=> q.status && q.count == 16'h0) // [RL14]
      else $error("rollover did not set the overflow flag");
   a_set_wins: assert property (ce && ovf_evt && st_w1c |=> q.status) // [RL14]
      else $error("overflow lost against a clear");
   a_off_hold: assert property (s_hold_case and !q.ctrl[GSTC_ON_BIT]
      |=> $stable(q.count)) // [RL6]
      else $error("count moved while the timer is off");
   a_gate_hold: assert property (s_hold_case and q.ctrl[GSTC_GATE_BIT] && gate_dig
      |=> $stable(q.count)) // [RL17]
      else $error("count moved while the gate is closed");
   a_sleep_hold: assert property (s_hold_case and sleep_mode
      && !(q.ctrl[GSTC_CS_BIT] && q.ctrl[GSTC_SYNC_BIT]) |=> $stable(q.count)) // [RL9]
      else $error("count moved in sleep outside asynchronous mode");
   a_osc_off: assert property (!q.ctrl[GSTC_OSC_BIT] |-> !low_power_osc_run) // [RL2]
      else $error("oscillator running with its enable clear");
   a_analog_zero: assert property (s_axi_rvalid && q.raddr == GSTC_OFF_PINS
      && $past(q.analog[GSTC_AN_CLK_BIT] && ce) |-> !s_axi_rdata[0]) // [RL12]
      else $error("analog pin read as digital one");
   a_irq_level: assert property (ce && ovf_evt && q.mask |=> irq) // [RL9]
      else $error("unmasked overflow did not raise the interrupt");
endmodule

// *** verilog/gstc_pkg.sv ***
// shared constants and types for the gated sixteen-bit timer/counter
package gstc_pkg;
   localparam logic [7:0] GSTC_OFF_COUNT_LO = 8'h00;
   localparam logic [7:0] GSTC_OFF_COUNT_HI = 8'h04;
   localparam logic [7:0] GSTC_OFF_STATUS = 8'h08;
   localparam logic [7:0] GSTC_OFF_MASK = 8'h0c;
   localparam logic [7:0] GSTC_OFF_CTRL = 8'h10;
   localparam logic [7:0] GSTC_OFF_ANALOG = 8'h14;
   localparam logic [7:0] GSTC_OFF_PINS = 8'h18;
   localparam int GSTC_ON_BIT = 0;
   localparam int GSTC_CS_BIT = 1;
   localparam int GSTC_SYNC_BIT = 2;
   localparam int GSTC_OSC_BIT = 3;
   localparam int GSTC_PS_LSB = 4;
   localparam int GSTC_GATE_BIT = 6;
   localparam int GSTC_AN_CLK_BIT = 0;
   localparam int GSTC_AN_GATE_BIT = 1;
   localparam logic [6:0] GSTC_CTRL_RST = 7'h00;
   localparam logic [1:0] GSTC_ANALOG_RST = 2'h3;
   localparam logic [15:0] GSTC_COUNT_MAX = 16'hffff;
   localparam int GSTC_INT_DIV = 4;
   localparam logic [1:0] GSTC_RESP_OKAY = 2'h0;
   localparam logic [1:0] GSTC_RESP_SLVERR = 2'h2;
   typedef enum logic [0:0] {
      GSTC_CH_IDLE = 1'b0,
      GSTC_CH_RESP = 1'b1
   } gstc_chan_t;
endpackage

// *** verilog/gstc_src_if.sv ***
// carries timer controls to the tick source and the tick back
interface gstc_src_if;
   logic on;
   logic cs;
   logic sync_dis;
   logic sleep;
   logic pin;
   logic tick;
   logic armed;
   modport core (output on, cs, sync_dis, sleep, pin, input tick, armed);
   modport src (input on, cs, sync_dis, sleep, pin, output tick, armed);
endinterface

// *** verilog/gstc_tick_src.sv ***
// timer increment source: internal divider or external edge detector
module gstc_tick_src
   import gstc_pkg::*;
#(
   parameter int INT_DIV = GSTC_INT_DIV
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   gstc_src_if.src sif
);
   localparam int DW = (INT_DIV > 2) ? $clog2(INT_DIV) : 1;
   localparam logic [DW-1:0] DLIM = DW'(INT_DIV - 1);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic a_prev;
      logic armed;
      logic [DW-1:0] div;
   } gstc_src_st_t;
   gstc_src_st_t q, d;
   logic cur, prev, rise, fall, ext_ok;

   always_comb begin
      d = q;
      // unsynchronised path looks at the pin directly
      cur = sif.sync_dis ? sif.pin : q.s2; // [RL3] [RL8]
      prev = sif.sync_dis ? q.a_prev : q.s3;
      rise = cur & ~prev;
      fall = ~cur & prev;
      d.s1 = sif.pin;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.a_prev = sif.pin;
      // only the asynchronous counter keeps going in sleep
      ext_ok = !sif.sleep || sif.sync_dis; // [RL9]
      if (!sif.on || !sif.cs) begin
         d.armed = 1'b0;
      end else if (fall) begin
         d.armed = 1'b1; // [RL16]
      end
      d.div = (q.div == DLIM) ? '0 : q.div + 1'b1;
      if (sif.cs) begin
         sif.tick = rise && q.armed && ext_ok; // [RL5] [RL16]
      end else begin
         sif.tick = (q.div == DLIM) && !sif.sleep; // [RL4] [RL5]
      end
      sif.armed = q.armed;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_arm_first: assert property (sif.tick && sif.cs |-> q.armed) // [RL16]
      else $error("external edge counted before a falling edge");
   a_int_spacing: assert property (ce && sif.tick && !sif.cs && !$past(sif.cs)
      |=> !sif.tick) // [RL5]
      else $error("internal ticks closer than the divider allows");
endmodule

// *** verif/gstc_ext_src.sv ***
// external clock source model: bursts of pulses on the count pin
module gstc_ext_src (
   input wire logic aclk,
   input wire logic start,
   input wire logic [7:0] n_pulses,
   input wire logic [7:0] half,
   output logic pin,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////////////
   // pin rests low between bursts, so every burst opens with a rising edge
   initial begin
      pin = 1'h0;
      busy = 1'h0;
      forever begin
         @(posedge aclk);
         if (start) begin
            busy <= 1'h1;
            repeat (n_pulses) begin
               pin <= 1'h1;
               repeat (half) @(posedge aclk);
               pin <= 1'h0;
               repeat (half) @(posedge aclk);
            end
            busy <= 1'h0;
         end
      end
   end
endmodule

// *** verif/gated_sixteen_bit_timer_counter_test.sv ***
// self-checking bench for the gated sixteen-bit timer/counter
module gated_sixteen_bit_timer_counter_test;
   timeunit 1ns;
   timeprecision 1ps;
   import gstc_pkg::*;
   localparam int DIV = 4;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, npl = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd_q;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, irq, osc_run, busy, ext;
   logic start = 1'h0, gate_n = 1'h1, osc_mode = 1'h0, sleep = 1'h0, lpo = 1'h0;
   logic [1:0] bresp, rresp, rs_q;
   logic [31:0] c;
   int fail_count = 0;
   int n_tests = 0;
   int i;
   always #20 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////////////
   gstc_timer #(.INT_DIV(DIV)) u_gstc_timer (
      .aclk(aclk), .aresetn(aresetn), .ce(1'h1),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .external_clock_input(ext), .lp_osc_input(lpo),
      .gate_input_pin_n(gate_n), .internal_oscillator_mode(osc_mode),
      .sleep_mode(sleep), .low_power_osc_run(osc_run), .irq(irq));
   gstc_ext_src u_gstc_ext_src (
      .aclk(aclk), .start(start), .n_pulses(npl), .half(8'h03), .pin(ext), .busy(busy));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chkr(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
      n_tests++;
      if ((g >= lo && g <= hi) !== 1'h1) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, lo);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int t;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (t = 0; t < 40; t++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid) begin
            rs_q = bresp;
            break;
         end
      end
      bready <= 1'h0;
      if (t == 40) chk(32'h1, 32'h0);
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a);
      int t;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (t = 0; t < 40; t++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
         if (rvalid) begin
            rd_q = rdata;
            rs_q = rresp;
            break;
         end
      end
      rready <= 1'h0;
      if (t == 40) chk(32'h1, 32'h0);
      @(posedge aclk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rd_q, e);
   endtask
   task automatic rcnt;
      c = 32'h0;
      rd(GSTC_OFF_COUNT_HI);
      c[15:8] = rd_q[7:0];
      rd(GSTC_OFF_COUNT_LO);
      c[7:0] = rd_q[7:0];
   endtask
   // timer is always stopped first: writing a running count is unsafe
   task automatic wcnt(input logic [15:0] v);
      wr(GSTC_OFF_CTRL, 32'h0);
      wr(GSTC_OFF_COUNT_HI, {24'h0, v[15:8]});
      wr(GSTC_OFF_COUNT_LO, {24'h0, v[7:0]});
   endtask
   task automatic run(input logic [31:0] ctl, input int w);
      wr(GSTC_OFF_CTRL, ctl);
      repeat (w) @(posedge aclk);
      wr(GSTC_OFF_CTRL, 32'h0);
      rcnt;
   endtask
   task automatic pulses(input logic [7:0] n);
      int t;
      npl <= n;
      start <= 1'h1;
      @(posedge aclk);
      start <= 1'h0;
      for (t = 0; t < 300; t++) begin
         @(posedge aclk);
         if (!busy) break;
      end
      repeat (4) @(posedge aclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rdc(GSTC_OFF_CTRL, 32'h0);
      rdc(GSTC_OFF_ANALOG, 32'h3);
      wr(GSTC_OFF_CTRL, 32'hff);
      rdc(GSTC_OFF_CTRL, 32'h7f);
      wr(8'h1c, 32'h1);
      chk(rs_q, GSTC_RESP_SLVERR);
      rdc(8'h1c, 32'h0);
      chk(rs_q, GSTC_RESP_SLVERR);
   endtask
   // four prescale ratios, window sized for four counts; sync bit set once
   task automatic t_ps;
      for (i = 0; i < 4; i++) begin
         wcnt(16'h0000);
         run(32'h1 | (32'(i) << 4) | ((i == 3) ? 32'h4 : 32'h0), DIV * 4 * (1 << i) - 4);
         chkr(c, 32'h3, 32'h5);
      end
   endtask
   task automatic t_ext;
      wr(GSTC_OFF_ANALOG, 32'h0);
      wcnt(16'h0000);
      wr(GSTC_OFF_CTRL, 32'h3);
      pulses(8'h05);
      rcnt;
      chk(c, 32'h4);
      wcnt(16'h0000);
      sleep <= 1'h1;
      wr(GSTC_OFF_CTRL, 32'h7);
      pulses(8'h05);
      rcnt;
      chk(c, 32'h4);
      wcnt(16'h0000);
      wr(GSTC_OFF_CTRL, 32'h3);
      pulses(8'h05);
      rcnt;
      chk(c, 32'h0);
      sleep <= 1'h0;
   endtask
   task automatic t_irq;
      wcnt(16'hfffd);
      run(32'h1, 24);
      chkr(c, 32'h3, 32'h5);
      rdc(GSTC_OFF_STATUS, 32'h1);
      chk(irq, 1'h0);
      wr(GSTC_OFF_MASK, 32'h1);
      chk(irq, 1'h1);
      wr(GSTC_OFF_STATUS, 32'h1);
      chk(irq, 1'h0);
      rdc(GSTC_OFF_STATUS, 32'h0);
      wr(GSTC_OFF_MASK, 32'h0);
   endtask
   task automatic t_gate;
      wcnt(16'h0000);
      run(32'h41, 40);
      chk(c, 32'h0);
      gate_n <= 1'h0;
      wcnt(16'h0000);
      run(32'h41, 36);
      chkr(c, 32'h9, 32'hb);
      gate_n <= 1'h1;
      wcnt(16'h0000);
      run(32'h01, 36);
      chkr(c, 32'h9, 32'hb);
   endtask
   task automatic t_pins;
      rdc(GSTC_OFF_PINS, 32'h2);
      wr(GSTC_OFF_ANALOG, 32'h3);
      rdc(GSTC_OFF_PINS, 32'h0);
      wr(GSTC_OFF_CTRL, 32'h8);
      chk(osc_run, 1'h0);
      osc_mode <= 1'h1;
      @(posedge aclk);
      chk(osc_run, 1'h1);
      wr(GSTC_OFF_CTRL, 32'h0);
      chk(osc_run, 1'h0);
      osc_mode <= 1'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("mismatches %0d of %0d checks", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_regs;
      t_ps;
      t_ext;
      t_irq;
      t_gate;
      t_pins;
      summarize;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      summarize;
   end
endmodule
